/* File: bench/mspc_core_assertions.sv */
// Purpose: Port checks for the execution unit
// Assumes: Zero wait states, results one cycle after the bus edge
// Notes: Bound to mspc_core from the bench top
`timescale 1ns/1ps
`default_nettype none
module mspc_core_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Results
	input wire logic [7:0] port_b_dir,
	input wire logic cmp_enable,
	input wire logic exec_done
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Instruction write taking effect
	wire logic go = psel && penable && pwrite && paddr == 8'h00;
	// Bus answer rules
	property p_ready; $past(presetn) |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("ready low");
	property p_err; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_hi; psel && penable && !pwrite |-> prdata[31:8] == 24'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper bits set");
	property p_irq; psel && !penable && !pwrite && paddr == 8'h00 |=>
		prdata == 32'h0; endproperty
	a_irq: assert property (p_irq) else $error("instr read");
	// Execution timing and effects
	property p_exec; go |=> exec_done; endproperty
	a_exec: assert property (p_exec) else $error("no done");
	property p_cause; exec_done |-> $past(go); endproperty
	a_cause: assert property (p_cause) else $error("stray done");
	property p_dir; !$stable(port_b_dir) |-> exec_done; endproperty
	a_dir: assert property (p_dir) else $error("dir moved");
	property p_cmp; $changed(cmp_enable) |-> exec_done; endproperty
	a_cmp: assert property (p_cmp) else $error("cmp moved");
	c_go: cover property (go);
	c_dir: cover property (!$stable(port_b_dir));
	c_cmp: cover property ($rose(cmp_enable));
endmodule // mspc_core_chk
`default_nettype wire

/* File: bench/mspc_core_tb.sv */
// Purpose: Self-checking bench for the execution unit
// Assumes: APB master with one idle cycle between transfers, two before an instruction write
// Notes: Reads queue a note, a monitor compares on completion
`timescale 1ns/1ps
`default_nettype none
module mspc_core_tb;
	// Stimulus and observation
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_val = 32'h0, t;
	logic pready, pslverr, cmp_enable, exec_done, rd_vld = 0;
	logic [7:0] dir_a, dir_b, dir_c, dir_d, dir_e, v, a, r;
	logic [7:0] dv[5];
	logic [1:0] pc = 2'h0;
	logic [11:0] word;
	logic [4:0] f, lo;
	logic [8:0] s;
	logic c, dg, fz, b;
	logic [31:0] seed = 32'hf1b5eb69;
	logic [31:0] exp_q[$];
	int fail_count = 0, n_tests = 0, cyc = 0, i, k;
	always #12.5 pclk = ~pclk;
	mspc_core mspc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_a_dir(dir_a), .port_b_dir(dir_b),
		.port_c_dir(dir_c), .port_d_dir(dir_d), .port_e_dir(dir_e),
		.cmp_enable(cmp_enable), .exec_done(exec_done));
	mspc_prog_mem mspc_prog_mem_i (.pc(pc), .word(word));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One bus transfer, held until pready is seen
	task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fail_count++;
		rd_val <= prdata;
		rd_vld <= !w;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [7:0] ad, input logic [7:0] d);
		xfer(1, ad, {24'h0, d});
	endtask
	task rd(input logic [7:0] ad, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		xfer(0, ad, 32'h0);
	endtask
	task exec(input logic [1:0] kd, input logic [4:0] fl);
		pc <= kd;
		@(posedge pclk);
		xfer(1, 8'h00, {20'h0, word | {7'h0, fl}});
	endtask
	// Compare each finished read with the oldest note
	always @(posedge pclk) begin
		if (rd_vld) begin
			rd_vld <= 0;
			chk(rd_val, exp_q.pop_front());
		end
	end
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		rd(8'h18, 8'hff);
		rd(8'h00, 8'h00);
		rd(8'h05, 8'h00);
		rd(8'h1c, 8'h00);
		// Direction writes on every port
		wr(8'h08, 8'h1f);
		for (i = 0; i < 5; i++) begin
			t = rnd();
			dv[i] = t[7:0];
			wr(8'h04, dv[i]);
			exec(2'h3, 5'(5 + i));
			rd(8'(8'h20 + 4 * i), dv[i]);
		end
		chk({dir_d, dir_c, dir_b, dir_a}, {dv[3], dv[2], dv[1], dv[0]});
		chk({24'h0, dir_e}, {24'h0, dv[4]});
		wr(8'h08, 8'h1e);
		exec(2'h3, 5'h05);
		rd(8'h04, dv[0]);
		// Comparator swap through a literal mode load
		wr(8'h98, 8'h5a);
		wr(8'h10, 8'h07);
		wr(8'h08, 8'hf3);
		wr(8'h0c, 8'h08);
		rd(8'h08, 8'hf8);
		wr(8'h04, 8'h00);
		exec(2'h3, 5'h06);
		rd(8'h04, 8'hff);
		rd(8'h18, 8'h00);
		chk({31'h0, cmp_enable}, 32'h1);
		rd(8'h10, 8'h07);
		rd(8'h98, 8'h5a);
		rd(8'h24, dv[1]);
		// Random moves and subtracts
		for (i = 0; i < 24; i++) begin
			k = i % 3;
			t = rnd();
			{dg, fz, c, a, v, f} = t[23:0];
			if (i < 3) begin
				v = (i == 1) ? 8'hff : 8'h00;
				a = v;
			end
			b = !fz && !c;
			s = {1'b0, v} - {1'b0, a} - {8'h0, b};
			lo = {1'b0, v[3:0]} - {1'b0, a[3:0]} - {4'h0, b};
			r = k == 0 ? v : k == 1 ? ~v : s[7:0];
			wr({1'b1, f, 2'b00}, v);
			wr(8'h04, a);
			wr(8'h10, {6'h0, dg, c});
			wr(8'h14, {7'h0, fz});
			exec(2'(k), f);
			rd(8'h04, r);
			if (k == 2)
				rd(8'h10, {5'h0, r == 0, !lo[4], !s[8]});
			else
				rd(8'h10, {5'h0, r == 0, dg, c});
			rd({1'b1, f, 2'b00}, v);
		end
		repeat (3) @(posedge pclk);
		give_verdict;
	end
endmodule // mspc_core_tb
bind mspc_core mspc_core_chk mspc_core_chk_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.port_b_dir(port_b_dir), .cmp_enable(cmp_enable),
	.exec_done(exec_done));
`default_nettype wire

/* File: bench/mspc_prog_mem.sv */
// Purpose: Program memory handing out base instruction words
// Assumes: File or port field is merged in by the fetcher
// Notes: Index 0 copy, 1 complement, 2 subtract, 3 port transfer
`timescale 1ns/1ps
`default_nettype none
module mspc_prog_mem (
	// Fetch index
	input wire logic [1:0] pc,
	// Instruction word
	output logic [11:0] word
);
	// Opcode table
	always_comb begin
		case (pc)
			2'h0: word = 12'h200;
			2'h1: word = 12'h240;
			2'h2: word = 12'h080;
			default: word = 12'h000;
		endcase
	end
endmodule // mspc_prog_mem
`default_nettype wire

/* File: design/mspc_alu.v */
// Purpose: Combinational result and flag logic for the accumulator moves
// Assumes: Operands are unsigned 8-bit values
// Notes: Borrow-in is used only when the fuse is programmed to zero
`timescale 1ns/1ps
`default_nettype none
`include "mspc_consts.vh"

module mspc_alu (
	// Operation select
	input wire [1:0] op_sel,
	// Operands
	input wire [7:0] file_register_operand,
	input wire [7:0] acc,
	// Flag and fuse inputs
	input wire carry_in,
	input wire carry_in_fuse,
	// Results
	output reg [7:0] result,
	output reg carry_out,
	output reg digit_carry_flag,
	output wire zero_out
);

	wire borrow_in;
	wire [8:0] diff;
	wire [4:0] nib_diff;

	// Borrow-in is the inverted carry when the fuse is programmed
	assign borrow_in = ~carry_in_fuse & ~carry_in;
	assign diff = {1'b0, file_register_operand} - {1'b0, acc} -
		{8'h00, borrow_in};
	assign nib_diff = {1'b0, file_register_operand[3:0]} -
		{1'b0, acc[3:0]} - {4'h0, borrow_in};

	// Result and flag selection
	always @* begin
		result = file_register_operand;
		carry_out = carry_in;
		digit_carry_flag = 1'b0;
		case (op_sel)
		`MSPC_ALU_COPY: begin
			result = file_register_operand;
		end
		`MSPC_ALU_COMP: begin
			result = file_register_operand ^ 8'hff;
		end
		`MSPC_ALU_SUB: begin
			result = diff[7:0];
			carry_out = ~diff[8];
			digit_carry_flag = ~nib_diff[4];
		end
		default: begin
			result = file_register_operand;
		end
		endcase
	end

	// Zero test on the eight-bit result
	assign zero_out = (result == 8'h00);

endmodule // mspc_alu
`default_nettype wire

/* File: design/mspc_consts.vh */
// Purpose: Shared constants of the move/subtract/port-control execution unit
// Assumes: APB byte addresses on paddr[7:0], 32-bit data words
// Notes: Offsets, field positions, reset values and opcode patterns
`ifndef MSPC_CONSTS_VH
`define MSPC_CONSTS_VH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define MSPC_OFF_INSTR 8'h00
`define MSPC_OFF_ACC 8'h04
`define MSPC_OFF_MODE 8'h08
`define MSPC_OFF_MODE_LIT 8'h0c
`define MSPC_OFF_STATUS 8'h10
`define MSPC_OFF_FUSE 8'h14
`define MSPC_OFF_CMP 8'h18
`define MSPC_OFF_DIR_A 8'h20
`define MSPC_OFF_DIR_B 8'h24
`define MSPC_OFF_DIR_C 8'h28
`define MSPC_OFF_DIR_D 8'h2c
`define MSPC_OFF_DIR_E 8'h30
// File register window starts here, one word per file register
`define MSPC_FILE_BIT 7

////////////////////////////////////////////////////////////////////////////
// Status field positions
`define MSPC_ST_CARRY 0
`define MSPC_ST_DIGIT 1
`define MSPC_ST_ZERO 2
// Fuse field position
`define MSPC_FUSE_CARRY_IN 0

////////////////////////////////////////////////////////////////////////////
// Reset values
`define MSPC_RST_ACC 8'h00
`define MSPC_RST_MODE 8'h00
`define MSPC_RST_DIR 8'hff
`define MSPC_RST_CMP 8'hff
`define MSPC_RST_FUSE 1'b1

////////////////////////////////////////////////////////////////////////////
// Opcode patterns
`define MSPC_OP_CTL_HI 8'h00
`define MSPC_OP_PORT_FIRST 4'h5
`define MSPC_OP_PORT_LAST 4'h9
`define MSPC_OP_MOV_W_FILE 7'h10
`define MSPC_OP_MOV_W_COM 7'h12
`define MSPC_OP_MOV_W_SUB 7'h04
// Port index of port B counted from port A
`define MSPC_PORT_B_IDX 3'h1

////////////////////////////////////////////////////////////////////////////
// Mode pointer values
`define MSPC_MODE_DIR_WR 8'h1f
`define MSPC_MODE_DIR_RD 8'h1e
`define MSPC_MODE_CMP_LO 4'h8

////////////////////////////////////////////////////////////////////////////
// ALU operation selects
`define MSPC_ALU_COPY 2'h0
`define MSPC_ALU_COMP 2'h1
`define MSPC_ALU_SUB 2'h2

`endif

/* File: design/mspc_core.v */
// Purpose: Executes port-control transfers and accumulator moves from APB
// Assumes: One instruction per APB write, single clock pclk at 40 MHz
// Notes: Slave answers with zero wait states; read data is registered
//
// Notes on behaviour
// - Opcode 0000 0000 ffff with field 5..9 moves data with port A..E.
// - The mode pointer picks the control register and read/write/swap.
// - Mode 1Fh writes the port direction register, changing pin roles.
// - A one in a direction bit makes an input, a zero an output.
// - Mode low nibble 8 on port B swaps with the comparator register.
// - Swapping in 00h enables the comparator; old value goes to W.
// - Port data is reached only as a file register, never this way.
// - Move file to W leaves the file intact and sets zero on 00h.
// - Complement move loads W with file XOR FFh and updates zero.
// - Subtract loads W with file minus W, eight bits, file intact.
// - Carry clears when W exceeds the file value, else it sets.
// - Digit carry clears on a borrow out of the low nibble.
// - Zero sets when the subtract result is 00h, else clears.
// - With the fuse at zero the inverted carry is also subtracted.
// - A literal mode load replaces only the low four mode bits.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mspc_consts.vh"

module mspc_core (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Port pin directions, one means input
	output reg [7:0] port_a_dir,
	output reg [7:0] port_b_dir,
	output reg [7:0] port_c_dir,
	output reg [7:0] port_d_dir,
	output reg [7:0] port_e_dir,
	// Comparator enable for port B
	output reg cmp_enable,
	// Pulse after each executed instruction
	output reg exec_done
);

	////////////////////////////////////////////////////////////////////
	// State
	reg [7:0] acc_q;
	reg [7:0] mode_q;
	reg carry_q;
	reg digit_q;
	reg zero_q;
	reg carry_in_fuse_q;
	reg [7:0] comparator_control_reg;
	reg [39:0] dir_q;
	reg [7:0] file_mem [0:31];

	////////////////////////////////////////////////////////////////////
	// Bus phase decode
	wire setup_ph;
	wire wr_acc;
	wire addr_ok;
	wire is_file;
	wire [4:0] file_idx;
	wire [11:0] opcode;

	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign is_file = paddr[`MSPC_FILE_BIT];
	assign file_idx = paddr[6:2];
	assign opcode = pwdata[11:0];

	// Mapped address check
	assign addr_ok = (paddr[1:0] == 2'b00) &&
		(is_file ||
		paddr == `MSPC_OFF_INSTR || paddr == `MSPC_OFF_ACC ||
		paddr == `MSPC_OFF_MODE || paddr == `MSPC_OFF_MODE_LIT ||
		paddr == `MSPC_OFF_STATUS || paddr == `MSPC_OFF_FUSE ||
		paddr == `MSPC_OFF_CMP ||
		(paddr >= `MSPC_OFF_DIR_A && paddr <= `MSPC_OFF_DIR_E));

	////////////////////////////////////////////////////////////////////
	// Instruction decode
	wire exec;
	wire is_ctl;
	wire is_mov;
	wire is_com;
	wire is_sub;
	wire [2:0] port_idx;
	wire [3:0] port_off;
	wire [7:0] file_val;
	wire [7:0] dir_sel;

	assign exec = wr_acc && addr_ok && paddr == `MSPC_OFF_INSTR;
	assign is_ctl = opcode[11:4] == `MSPC_OP_CTL_HI &&
		opcode[3:0] >= `MSPC_OP_PORT_FIRST &&
		opcode[3:0] <= `MSPC_OP_PORT_LAST;
	assign is_mov = opcode[11:5] == `MSPC_OP_MOV_W_FILE;
	assign is_com = opcode[11:5] == `MSPC_OP_MOV_W_COM;
	assign is_sub = opcode[11:5] == `MSPC_OP_MOV_W_SUB;
	// Offset from port A; only the low three bits are needed
	assign port_off = opcode[3:0] - `MSPC_OP_PORT_FIRST;
	assign port_idx = port_off[2:0];
	assign file_val = file_mem[opcode[4:0]];
	assign dir_sel = dir_q[{port_idx, 3'b000} +: 8];

	////////////////////////////////////////////////////////////////////
	// Control register access kind from the mode pointer
	wire ctl_dir_wr;
	wire ctl_dir_rd;
	wire ctl_cmp_xchg;

	// A mode with no access kind leaves every register alone
	// Full compare first, then the port B comparator nibble
	assign ctl_dir_wr = is_ctl && mode_q == `MSPC_MODE_DIR_WR;
	assign ctl_dir_rd = is_ctl && mode_q == `MSPC_MODE_DIR_RD;
	assign ctl_cmp_xchg = is_ctl && !ctl_dir_wr && !ctl_dir_rd &&
		port_idx == `MSPC_PORT_B_IDX &&
		mode_q[3:0] == `MSPC_MODE_CMP_LO;

	////////////////////////////////////////////////////////////////////
	// Arithmetic unit
	reg [1:0] alu_sel;
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_digit;
	wire alu_z;

	// Operation select from opcode
	always @* begin
		alu_sel = `MSPC_ALU_COPY;
		if (is_com) begin
			alu_sel = `MSPC_ALU_COMP;
		end else if (is_sub) begin
			alu_sel = `MSPC_ALU_SUB;
		end
	end

	mspc_alu u_alu (
		.op_sel(alu_sel),
		.file_register_operand(file_val),
		.acc(acc_q),
		.carry_in(carry_q),
		.carry_in_fuse(carry_in_fuse_q),
		.result(alu_res),
		.carry_out(alu_c),
		.digit_carry_flag(alu_digit),
		.zero_out(alu_z)
	);

	////////////////////////////////////////////////////////////////////
	// Accumulator, flags and control registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= `MSPC_RST_ACC;
			mode_q <= `MSPC_RST_MODE;
			carry_q <= 1'b0;
			digit_q <= 1'b0;
			zero_q <= 1'b0;
			carry_in_fuse_q <= `MSPC_RST_FUSE;
			comparator_control_reg <= `MSPC_RST_CMP;
			dir_q <= {5{`MSPC_RST_DIR}};
		end else if (exec) begin
			// Port control transfer leaves all flags alone
			if (ctl_dir_wr) begin
				dir_q[{port_idx, 3'b000} +: 8] <= acc_q;
			end else if (ctl_dir_rd) begin
				acc_q <= dir_sel;
			end else if (ctl_cmp_xchg) begin
				comparator_control_reg <= acc_q;
				acc_q <= comparator_control_reg;
			end else if (is_mov || is_com) begin
				// Copy and complement touch only the zero flag
				acc_q <= alu_res;
				zero_q <= alu_z;
			end else if (is_sub) begin
				acc_q <= alu_res;
				carry_q <= alu_c;
				digit_q <= alu_digit;
				zero_q <= alu_z;
			end
		end else if (wr_acc && addr_ok) begin
			// Plain register writes; refused addresses are ignored
			case (paddr)
			`MSPC_OFF_ACC: begin
				acc_q <= pwdata[7:0];
			end
			`MSPC_OFF_MODE: begin
				mode_q <= pwdata[7:0];
			end
			`MSPC_OFF_MODE_LIT: begin
				mode_q <= {mode_q[7:4], pwdata[3:0]};
			end
			`MSPC_OFF_STATUS: begin
				carry_q <= pwdata[`MSPC_ST_CARRY];
				digit_q <= pwdata[`MSPC_ST_DIGIT];
				zero_q <= pwdata[`MSPC_ST_ZERO];
			end
			`MSPC_OFF_FUSE: begin
				carry_in_fuse_q <= pwdata[`MSPC_FUSE_CARRY_IN];
			end
			default: begin
				acc_q <= acc_q;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// File registers, port data among them, written only by the bus
	// Not reset, so software writes one before reading it
	always @(posedge pclk) begin
		if (wr_acc && is_file && paddr[1:0] == 2'b00) begin
			file_mem[file_idx] <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin direction and comparator outputs straight from flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_a_dir <= `MSPC_RST_DIR;
			port_b_dir <= `MSPC_RST_DIR;
			port_c_dir <= `MSPC_RST_DIR;
			port_d_dir <= `MSPC_RST_DIR;
			port_e_dir <= `MSPC_RST_DIR;
			cmp_enable <= 1'b0;
			exec_done <= 1'b0;
		end else begin
			exec_done <= exec;
			if (exec && ctl_dir_wr) begin
				// One bit is an input pin, zero an output
				case (port_idx)
				3'h0: port_a_dir <= acc_q;
				3'h1: port_b_dir <= acc_q;
				3'h2: port_c_dir <= acc_q;
				3'h3: port_d_dir <= acc_q;
				3'h4: port_e_dir <= acc_q;
				default: port_a_dir <= port_a_dir;
				endcase
			end
			if (exec && ctl_cmp_xchg) begin
				cmp_enable <= (acc_q == 8'h00);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data mux
	// Unmapped addresses and unaligned ones outside the file window read as zero
	reg [31:0] rd_d;

	always @* begin
		rd_d = 32'h0000_0000;
		if (is_file) begin
			rd_d = {24'h000000, file_mem[file_idx]};
		end else begin
			case (paddr)
			`MSPC_OFF_ACC: rd_d = {24'h000000, acc_q};
			`MSPC_OFF_MODE: rd_d = {24'h000000, mode_q};
			`MSPC_OFF_MODE_LIT: rd_d = {24'h000000, mode_q};
			`MSPC_OFF_STATUS: rd_d = {29'h00000000, zero_q, digit_q,
				carry_q};
			`MSPC_OFF_FUSE: rd_d = {31'h00000000, carry_in_fuse_q};
			`MSPC_OFF_CMP: rd_d = {24'h000000,
				comparator_control_reg};
			`MSPC_OFF_DIR_A: rd_d = {24'h000000, dir_q[7:0]};
			`MSPC_OFF_DIR_B: rd_d = {24'h000000, dir_q[15:8]};
			`MSPC_OFF_DIR_C: rd_d = {24'h000000, dir_q[23:16]};
			`MSPC_OFF_DIR_D: rd_d = {24'h000000, dir_q[31:24]};
			`MSPC_OFF_DIR_E: rd_d = {24'h000000, dir_q[39:32]};
			default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// APB answer, captured in the setup cycle so it stands in access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// Zero wait states from the first edge out of reset
			pready <= 1'b1;
			if (setup_ph) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr <= ~addr_ok;
			end
		end
	end

endmodule // mspc_core
`default_nettype wire
